// file: core/sbsc_agent_end.sv
/*
 * agent end: secondary masters, target select, system error and the
 * serial clock mask source. assumes its own clock near the bridge clock.
 */
`timescale 1ns/1ps
module sbsc_agent_end (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	sbsc_if.agent                             link,
	input  wire logic [sbsc_pkg::NUM_REQ-1:0] wantBus,
	input  wire logic [sbsc_pkg::NUM_CLK-1:0] serialMask,
	input  wire logic                         raiseSystemErr,
	input  wire logic                         selectAck,
	input  wire logic                         slowOnly,
	output logic      [sbsc_pkg::NUM_REQ-1:0] grantSeen,
	output logic                              parityErrSeen
);
	import sbsc_pkg::*;
	logic [NUM_REQ+2:0] syncOut;   // grants, clock, reset, parity
	logic               clkLast;   // previous clock sample
	logic [3:0]         bitIdx;    // serial bit position
	////////////////////////////////////////////////////////////////////////
	// feedback clock and pin synchronisers
	assign link.secClockInput = link.secClockOutputs[0];
	sbsc_sync #(.WIDTH(NUM_REQ + 3)) u_sync (
		.clk        (clk),
		.rst_n      (rst_n),
		.ce         (ce),
		.async      ({link.secParityErrN, link.secResetN,
			link.secClockOutputs[0], link.gntN}),
		.resetValue ('0),
		.synced     (syncOut)
	);
	// request, select, error and capability drive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.reqN <= '1;
			link.devselN <= 1'b1;
			link.serrOe <= 1'b0;
			link.fastAgentOe <= 1'b0;
			grantSeen <= '0;
			parityErrSeen <= 1'b0;
		end else if (ce) begin
			link.reqN <= ~wantBus;                               // RULE3
			link.devselN <= ~selectAck;
			link.serrOe <= raiseSystemErr;                       // RULE2
			link.fastAgentOe <= slowOnly;                        // RULE8
			grantSeen <= ~syncOut[NUM_REQ-1:0];
			parityErrSeen <= ~syncOut[NUM_REQ+2];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// serial mask: present bit, advance on falling clock while in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkLast <= 1'b0;
			bitIdx <= 4'h0;
			link.clockDisableSerialIn <= 1'b0;
		end else if (ce) begin
			clkLast <= syncOut[NUM_REQ];
			if (syncOut[NUM_REQ+1]) begin
				bitIdx <= 4'h0;
			end else if (clkLast && !syncOut[NUM_REQ] && bitIdx < MASK_BITS) begin
				bitIdx <= bitIdx + 4'h1;                         // RULE14
			end
			link.clockDisableSerialIn <= (bitIdx < MASK_BITS)
				? serialMask[bitIdx] : 1'b0;
		end
	end
endmodule : sbsc_agent_end

// file: core/sbsc_bridge_end.sv
/*
 * bridge end: parity/system error, arbiter, secondary reset, clock outputs,
 * serial clock mask, power clock stop, straps and master-abort timer.
 * assumes clk is the primary clock and rst_n the primary reset.
 */
// Functional notes
// (RULE1) parity error low, then high, then release
// (RULE2) sense shared system error line as input
// (RULE3) masters request bus with own low line
// (RULE4) grant stays off two secondary clocks
// (RULE5) drive bus lines when idle and parked
// (RULE6) secondary reset follows primary reset or bit
// (RULE7) reset tristates controls, drives bus zeros
// (RULE8) capability high allows fast, low slow
// (RULE9) upstream slow pulls secondary capability low
// (RULE10) strap low internal arbiter, high external
// (RULE11) external mode: request0 grant, grant0 request
// (RULE12) ten clock outputs synchronous to primary clock
// (RULE13) disable clocks by bits or serial mask
// (RULE14) shift mask after primary reset release
// (RULE15) serial low enables all, high forces high
// (RULE16) low power with strap stops clocks low
// (RULE17) speed strap high fast, low slow
// (RULE18) test mode: strap low shift, high parallel
// (RULE19) mode input a high selects default mode
// (RULE20) master abort without select in five
// (RULE21) at most one grant including own
// (RULE22) serial mask sampled on secondary clock
`timescale 1ns/1ps
module sbsc_bridge_end (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	sbsc_if.bridge                             link,
	input  wire logic                          upstreamFastCapable,
	input  wire logic                          centralFunctionStrapN,
	input  wire logic                          busPowerClockStrap,
	input  wire logic                          speedConfigStrap,
	input  wire logic                          modeSelectA,
	input  wire logic                          modeSelectB,
	input  wire logic                          testMode,
	input  wire logic                          secResetBit,
	input  wire logic [sbsc_pkg::NUM_CLK-1:0]  clockDisableBits,
	input  wire logic                          powerStateD3,
	input  wire logic                          dataParityErr,
	input  wire logic                          ownReq,
	input  wire logic                          secBusIdle,
	input  wire logic                          ownFrameStart,
	output logic                               ownGrant,
	output logic                               systemErrSeen,
	output logic                               fastMode,
	output logic                               scanShift,
	output logic                               compatMode,
	output logic                               masterAbort,
	output logic [sbsc_pkg::NUM_CLK-1:0]       clockMask
);
	import sbsc_pkg::*;
	logic [SYNC_W-1:0]  syncIn;      // all pin inputs
	logic [SYNC_W-1:0]  syncOut;     // synchronised pins
	logic               sClk;        // synced secondary clock
	logic               sClkLast;    // previous sample
	logic               secEdge;     // secondary rising edge
	logic               maskIn;      // synced serial mask bit
	logic [NUM_REQ-1:0] reqSync;     // synced requests, active low
	logic               serrSync;    // synced system error
	logic               fastWire;    // synced capability wire
	logic               devselSync;  // synced select, active low
	logic               upFast;      // synced upstream capability
	logic               cfnN;        // synced central strap
	logic               bpcc;        // synced power clock strap
	logic               speed;       // synced speed strap
	logic               msA;         // synced mode select a
	logic               tMode;       // synced test mode
	logic               loadActive;  // serial mask loading
	logic [3:0]         loadCount;   // bits shifted so far
	logic [2:0]         divCount;    // clock divider
	logic               divClk;      // divided clock level
	logic [IDX_W-1:0]   grantIdx;    // current grant holder
	logic [IDX_W-1:0]   lastIdx;     // round-robin pointer
	logic [NUM_REQ:0]   wants;       // requesters incl own
	logic [NUM_REQ:0]   eligible;    // requesters out of gap
	logic               releaseHolder; // holder leaves on this edge
	logic [1:0]         gap [NUM_REQ+1]; // per grant idle count
	logic               extMode;     // external arbiter
	logic               inReset;     // secondary reset active
	logic [2:0]         abortCount;  // select wait counter
	logic               abortWait;   // waiting for select
	sbsc_perr_type      perrState;   // parity error sequence
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	assign syncIn = {testMode, modeSelectB, modeSelectA, speedConfigStrap,
		busPowerClockStrap, centralFunctionStrapN, upstreamFastCapable,
		link.devselN, link.secFastCapable, link.secSystemErrN, link.reqN,
		link.clockDisableSerialIn, link.secClockInput};
	sbsc_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk        (clk),
		.rst_n      (rst_n),
		.ce         (ce),
		.async      (syncIn),
		.resetValue ('0),
		.synced     (syncOut)
	);
	assign sClk = syncOut[0];
	assign maskIn = syncOut[1];
	assign reqSync = syncOut[10:2];
	assign serrSync = syncOut[11];                               // RULE2
	assign fastWire = syncOut[12];
	assign devselSync = syncOut[13];
	assign upFast = syncOut[14];
	assign cfnN = syncOut[15];
	assign bpcc = syncOut[16];
	assign speed = syncOut[17];
	assign msA = syncOut[18];
	assign tMode = syncOut[20];
	assign secEdge = sClk & ~sClkLast;
	assign extMode = cfnN;                                       // RULE10
	assign inReset = loadActive | secResetBit;
	////////////////////////////////////////////////////////////////////////
	// secondary clock edge finder
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sClkLast <= 1'b0;
		end else if (ce) begin
			sClkLast <= sClk;
		end
	end
	// serial mask load after primary reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loadActive <= 1'b1;
			loadCount <= 4'h0;
			clockMask <= '0;
		end else if (ce && loadActive && secEdge) begin
			clockMask <= {maskIn, clockMask[NUM_CLK-1:1]};     // RULE14 RULE22
			loadCount <= loadCount + 4'h1;
			if (loadCount == MASK_BITS - 4'h1) begin
				loadActive <= 1'b0;
			end
		end
	end
	// secondary reset out, held through mask load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.secResetN <= 1'b0;                              // RULE6
		end else if (ce) begin
			link.secResetN <= ~inReset;                          // RULE6
		end
	end
	////////////////////////////////////////////////////////////////////////
	// clock divider and gated outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divCount <= 3'h0;
			divClk <= 1'b0;
		end else if (ce) begin
			if (divCount == CLK_HALF) begin
				divCount <= 3'h0;
				divClk <= ~divClk;                               // RULE12
			end else begin
				divCount <= divCount + 3'h1;
			end
		end
	end
	generate
		for (genvar c = 0; c < NUM_CLK; c++) begin : g_clk
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					link.secClockOutputs[c] <= 1'b0;
				end else if (ce) begin
					if (powerStateD3 && bpcc) begin
						link.secClockOutputs[c] <= 1'b0;         // RULE16
					end else if (clockMask[c] || clockDisableBits[c]) begin
						link.secClockOutputs[c] <= 1'b1;         // RULE13 RULE15
					end else begin
						link.secClockOutputs[c] <= divClk;       // RULE12
					end
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	// round-robin pick after the last holder
	function automatic logic [IDX_W-1:0] pickNext(
		input logic [NUM_REQ:0] elig,
		input logic [IDX_W-1:0] last
	);
		logic [IDX_W-1:0] found;
		int               idx;
		found = NONE_IDX;
		for (int k = NUM_REQ + 1; k >= 1; k--) begin
			idx = (int'(last) + k) % (NUM_REQ + 1);
			if (elig[idx]) begin
				found = IDX_W'(idx);
			end
		end
		return found;
	endfunction : pickNext
	assign wants = {ownReq, ~reqSync};                           // RULE3
	// own park holds until an outside master asks, so parking stays steady
	assign releaseHolder = secBusIdle && ((grantIdx == OWN_IDX) ? (wants[NUM_REQ-1:0] != '0)
		: (wants != ((NUM_REQ + 1)'(1) << grantIdx)));
	generate
		for (genvar g = 0; g <= NUM_REQ; g++) begin : g_gap
			assign eligible[g] = wants[g] && (gap[g] == 2'h0);   // RULE4
			// idle count after a grant leaves
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					gap[g] <= 2'h0;
				end else if (ce && secEdge) begin
					if (grantIdx == IDX_W'(g) && !inReset && !extMode
						&& releaseHolder) begin
						gap[g] <= GRANT_GAP;                     // RULE4
					end else if (gap[g] != 2'h0) begin
						gap[g] <= gap[g] - 2'h1;
					end
				end
			end
		end
	endgenerate
	// arbiter holder, parks on own slot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			grantIdx <= NONE_IDX;
			lastIdx <= OWN_IDX;
		end else if (ce && secEdge) begin
			if (inReset || extMode) begin
				grantIdx <= NONE_IDX;                            // RULE10
			end else if (grantIdx == NONE_IDX) begin
				if (eligible != '0) begin
					grantIdx <= pickNext(eligible, lastIdx);     // RULE21
					lastIdx <= pickNext(eligible, lastIdx);
				end else if (gap[NUM_REQ] == 2'h0) begin
					grantIdx <= OWN_IDX;                         // RULE5
				end
			end else if (releaseHolder) begin
				grantIdx <= NONE_IDX;                            // RULE21
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// grant pins and their drive enables
	generate
		for (genvar p = 0; p < NUM_REQ; p++) begin : g_gnt
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					link.gntOutN[p] <= 1'b1;
					link.gntOe[p] <= 1'b0;
				end else if (ce) begin
					if (inReset) begin
						link.gntOutN[p] <= 1'b1;
						link.gntOe[p] <= 1'b0;                   // RULE7
					end else if (extMode) begin
						link.gntOutN[p] <= (p == 0) ? ~ownReq : 1'b1; // RULE11
						link.gntOe[p] <= (p == 0);
					end else begin
						link.gntOutN[p] <= (grantIdx != IDX_W'(p));
						link.gntOe[p] <= 1'b1;
					end
				end
			end
		end
	endgenerate
	// own grant, bus parking and reset drive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ownGrant <= 1'b0;
			link.busOe <= 1'b1;                                  // RULE7
			link.adOut <= '0;
			link.secCmdByteEn <= '0;
			link.secParity <= 1'b0;
		end else if (ce) begin
			ownGrant <= !inReset && (extMode ? !reqSync[0]       // RULE11
				: grantIdx == OWN_IDX);
			link.busOe <= inReset || (secBusIdle                 // RULE7
				&& (extMode ? !reqSync[0] : grantIdx == OWN_IDX)); // RULE5
			link.adOut <= '0;
			link.secCmdByteEn <= '0;
			link.secParity <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// parity error: low, high for one secondary clock, release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			perrState <= PERR_IDLE;
		end else if (ce) begin
			if (inReset) begin
				perrState <= PERR_IDLE;                          // RULE7
			end else if (dataParityErr) begin
				perrState <= PERR_LOW;                           // RULE1
			end else if (secEdge) begin
				unique case (perrState)
					PERR_IDLE: perrState <= PERR_IDLE;
					PERR_LOW:  perrState <= PERR_HIGH;           // RULE1
					PERR_HIGH: perrState <= PERR_IDLE;           // RULE1
					default:   perrState <= PERR_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link.perrOutN <= 1'b1;
			link.perrOe <= 1'b0;
		end else if (ce) begin
			link.perrOutN <= (perrState != PERR_LOW);            // RULE1
			link.perrOe <= (perrState != PERR_IDLE) && !inReset; // RULE7
		end
	end
	////////////////////////////////////////////////////////////////////////
	// master abort timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abortWait <= 1'b0;
			abortCount <= 3'h0;
			masterAbort <= 1'b0;
		end else if (ce) begin
			masterAbort <= 1'b0;
			if (ownFrameStart) begin
				abortWait <= 1'b1;
				abortCount <= 3'h0;
			end else if (abortWait && !devselSync) begin
				abortWait <= 1'b0;                               // RULE20
			end else if (abortWait && secEdge) begin
				abortCount <= abortCount + 3'h1;
				if (abortCount == DEVSEL_LIMIT - 3'h1) begin
					abortWait <= 1'b0;
					masterAbort <= 1'b1;                         // RULE20
				end
			end
		end
	end
	// status, capability and strap decode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			systemErrSeen <= 1'b0;
			fastMode <= 1'b0;
			scanShift <= 1'b0;
			compatMode <= 1'b0;
			link.fastBridgeOe <= 1'b0;
		end else if (ce) begin
			systemErrSeen <= !serrSync;                          // RULE2
			fastMode <= fastWire && speed;                       // RULE8 RULE17
			scanShift <= tMode && !speed;                        // RULE18
			compatMode <= msA;                                   // RULE19
			link.fastBridgeOe <= !upFast;                        // RULE9
		end
	end
endmodule : sbsc_bridge_end

// file: core/sbsc_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes each bit is independent; no bus coherence is kept.
 */
`timescale 1ns/1ps
module sbsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async,
	input  wire logic [WIDTH-1:0] resetValue,
	output logic      [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1; // first stage, read only by second
	logic [WIDTH-1:0] seeded; // reset seed captured on release
	////////////////////////////////////////////////////////////////////////
	// seed register so reset takes a constant, value loads after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seeded <= '0;
		end else begin
			seeded <= resetValue;
		end
	end
	// two flops in series
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			synced <= '0;
		end else if (ce) begin
			stage1 <= async;
			synced <= stage1;
		end
	end
endmodule : sbsc_sync

// file: shared/sbsc_if.sv
/*
 * secondary bus wires between the bridge end and the agent end.
 * assumes pull-ups on every open or released line.
 */
`timescale 1ns/1ps
interface sbsc_if;
	import sbsc_pkg::*;
	logic [NUM_CLK-1:0] secClockOutputs;     // divided clocks from the bridge
	logic               secClockInput;       // feedback clock into the bridge
	logic               clockDisableSerialIn;// serial mask stream
	logic               secResetN;           // secondary reset
	logic [NUM_REQ-1:0] reqN;                // requests from masters
	logic [NUM_REQ-1:0] gntOutN;             // grant drive values
	logic [NUM_REQ-1:0] gntOe;               // grant drive enables
	logic [NUM_REQ-1:0] gntN;                // resolved grant wires
	logic               perrOutN;            // parity error drive value
	logic               perrOe;              // parity error enable
	logic               secParityErrN;       // resolved parity error wire
	logic               serrOe;              // agent pulls system error low
	logic               secSystemErrN;       // resolved system error wire
	logic               fastBridgeOe;        // bridge pulls capability low
	logic               fastAgentOe;         // agent pulls capability low
	logic               secFastCapable;      // resolved capability wire
	logic               devselN;             // target select seen by bridge
	logic [AD_W-1:0]    adOut;               // parked address/data value
	logic [CBE_W-1:0]   secCmdByteEn;        // parked command/byte enables
	logic               secParity;           // parked parity value
	logic               busOe;               // parked bus drive enable
	// wire resolution with pull-ups
	assign gntN = (gntOutN | ~gntOe);
	assign secParityErrN = perrOe ? perrOutN : 1'b1;
	assign secSystemErrN = ~serrOe;
	assign secFastCapable = ~(fastBridgeOe | fastAgentOe);
	modport bridge (
		output secClockOutputs, gntOutN, gntOe, perrOutN, perrOe, secResetN,
		output fastBridgeOe, adOut, secCmdByteEn, secParity, busOe,
		input  secClockInput, clockDisableSerialIn, reqN, secSystemErrN,
		input  secFastCapable, devselN
	);
	modport agent (
		input  secClockOutputs, gntN, secParityErrN, secResetN, secFastCapable,
		output secClockInput, clockDisableSerialIn, reqN, serrOe, fastAgentOe,
		output devselN
	);
endinterface : sbsc_if

// file: shared/sbsc_pkg.sv
/*
 * constants shared by both ends of the secondary-side control link.
 * assumes one primary clock on each end; secondary clock is sampled.
 */
package sbsc_pkg;
	localparam int NUM_REQ = 9;                     // external request/grant pairs
	localparam int NUM_CLK = 10;                    // secondary clock outputs
	localparam int AD_W = 32;                       // address/data width
	localparam int CBE_W = 4;                       // command/byte-enable width
	localparam int IDX_W = 4;                       // grant index width
	localparam logic [IDX_W-1:0] OWN_IDX = 4'h9;    // bridge's own grant slot
	localparam logic [IDX_W-1:0] NONE_IDX = 4'hF;   // no grant asserted
	localparam logic [1:0] GRANT_GAP = 2'h2;        // idle secondary clocks
	localparam logic [2:0] DEVSEL_LIMIT = 3'h5;     // clocks to wait for select
	localparam logic [2:0] CLK_HALF = 3'h3;         // divider terminal count
	localparam logic [3:0] MASK_BITS = 4'hA;        // serial mask length
	localparam int SYNC_W = 21;                     // pins through the synchroniser
	typedef enum logic [1:0] {
		PERR_IDLE = 2'b00,
		PERR_LOW  = 2'b01,
		PERR_HIGH = 2'b10
	} sbsc_perr_type;
endpackage : sbsc_pkg

// file: tb/sbsc_checker.sv
/* timing checks on the secondary link wires.
   assumes clk and rst_n are the bridge end's clock and reset. */
`timescale 1ns/1ps
module sbsc_checker (
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic [sbsc_pkg::NUM_CLK-1:0] secClockOutputs,
	input wire logic                        secResetN,
	input wire logic [sbsc_pkg::NUM_REQ-1:0] gntN,
	input wire logic [sbsc_pkg::NUM_REQ-1:0] gntOe,
	input wire logic                        perrOutN,
	input wire logic                        perrOe,
	input wire logic                        busOe,
	input wire logic [sbsc_pkg::AD_W-1:0]    adOut,
	input wire logic [sbsc_pkg::CBE_W-1:0]   secCmdByteEn,
	input wire logic                        secParity
);
	import sbsc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_reset_bus_zero: assert property (!secResetN [*2] |-> busOe && adOut == '0 &&
		secCmdByteEn == '0 && !secParity) else $error("bus not zero in reset");
	a_reset_no_drive: assert property (!secResetN [*2] |-> gntOe == '0 && !perrOe)
		else $error("control driven in reset");
	a_one_grant: assert property ($countones(~gntN) <= 1)
		else $error("two grants at once");
	for (genvar i = 0; i < NUM_REQ; i++) begin : g_gap
		a_grant_gap: assert property ($rose(gntN[i]) |=> gntN[i] [*8] ##1 gntN[i] [*8])
			else $error("grant reasserted too soon");
	end
	a_perr_release: assert property ($fell(perrOe) |-> $past(perrOutN) &&
		$past(perrOutN, 2)) else $error("parity error released while low");
	a_perr_low_first: assert property ($rose(perrOe) |-> !perrOutN)
		else $error("parity error not low first");
	a_clk_low_half: assert property ($rose(secClockOutputs[0]) |->
		!$past(secClockOutputs[0], 3)) else $error("clock low half short");
	a_parked_drive: assert property (busOe && secResetN |-> &gntN[NUM_REQ-1:1]
		&& (gntN[0] || !gntOe[1])) else $error("bus driven while other granted");
endmodule : sbsc_checker

// file: tb/secondary_bus_side_control_tb.sv
/* bench joining bridge end and agent end over the link.
   assumes the agent feeds clock output 0 back as the secondary clock. */
`timescale 1ns/1ps
module secondary_bus_side_control_tb;
	import sbsc_pkg::*;
	logic clk = 0, rst_n = 0, upF = 1, cfsN = 0, bpcs = 0, spd = 1, msA = 1, msB = 0;
	logic tMode = 0, srBit = 0, d3 = 0, dpe = 0, ownReq = 0, idle = 1, frm = 0;
	logic serr = 0, selAck = 0, slow = 0;
	logic [NUM_CLK-1:0] disBits = '0, mask = 10'h2A4, clockMask;
	logic [NUM_REQ-1:0] want = '0, grantSeen;
	logic ownGrant, serrSeen, fastMode, scanShift, compatMode, mAbort, perrSeen;
	int fails = 0, nCompared = 0, cycles = 0;
	sbsc_if linkBus ();
	sbsc_bridge_end sbsc_bridge_end_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(linkBus),
		.upstreamFastCapable(upF), .centralFunctionStrapN(cfsN), .busPowerClockStrap(bpcs),
		.speedConfigStrap(spd), .modeSelectA(msA), .modeSelectB(msB), .testMode(tMode),
		.secResetBit(srBit), .clockDisableBits(disBits), .powerStateD3(d3),
		.dataParityErr(dpe), .ownReq(ownReq), .secBusIdle(idle), .ownFrameStart(frm),
		.ownGrant(ownGrant), .systemErrSeen(serrSeen), .fastMode(fastMode),
		.scanShift(scanShift), .compatMode(compatMode), .masterAbort(mAbort),
		.clockMask(clockMask));
	sbsc_agent_end sbsc_agent_end_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(linkBus),
		.wantBus(want), .serialMask(mask), .raiseSystemErr(serr), .selectAck(selAck),
		.slowOnly(slow), .grantSeen(grantSeen), .parityErrSeen(perrSeen));
	sbsc_checker sbsc_checker_i (.clk(clk), .rst_n(rst_n), .secResetN(linkBus.secResetN),
		.secClockOutputs(linkBus.secClockOutputs), .gntN(linkBus.gntN), .gntOe(linkBus.gntOe),
		.perrOutN(linkBus.perrOutN), .perrOe(linkBus.perrOe), .busOe(linkBus.busOe),
		.adOut(linkBus.adOut), .secCmdByteEn(linkBus.secCmdByteEn),
		.secParity(linkBus.secParity));
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wait_sec_up;
		for (int i = 0; i < 400 && linkBus.secResetN !== 1'b1; i++) tick(1);
	endtask : wait_sec_up
	task tally_and_finish;
		$display("compared %0d mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////
	task t_mask_clocks;
		wait_sec_up();
		check("secResetN", linkBus.secResetN, 1);
		check("clockMask", clockMask, mask);
		disBits = 10'h300;
		tick(4);
		for (int i = 0; i < 8; i++) begin
			tick(1);
			check("disabled clocks", linkBus.secClockOutputs & 10'h3A4, 10'h3A4);
		end
		disBits = '0;
		$display("mask and clocks done");
	endtask : t_mask_clocks
	task t_straps;
		for (int i = 0; i < 4; i++) begin
			msA = i[1];
			msB = i[0];
			spd = i[0];
			tMode = 1;
			tick(6);
			check("compatMode", compatMode, i[1]);
			check("scanShift", scanShift, !i[0]);
			check("fastMode", fastMode, i[0]);
		end
		upF = 0;
		tick(6);
		check("secFastCapable", linkBus.secFastCapable, 0);
		check("fastMode slow", fastMode, 0);
		upF = 1;
		tMode = 0;
		$display("straps done");
	endtask : t_straps
	task t_errors;
		logic seen;
		seen = 0;
		serr = 1;
		tick(6);
		check("systemErrSeen", serrSeen, 1);
		serr = 0;
		tick(6);
		check("systemErrSeen off", serrSeen, 0);
		dpe = 1;
		tick(1);
		dpe = 0;
		tick(1);
		check("secParityErrN", linkBus.secParityErrN, 0);
		for (int i = 0; i < 30; i++) begin
			tick(1);
			if (perrSeen === 1'b1) seen = 1;
		end
		check("parityErrSeen", seen, 1);
		check("perrOe", linkBus.perrOe, 0);
		$display("errors done");
	endtask : t_errors
	task t_arbiter;
		want = 9'h006;
		for (int i = 0; i < 200 && linkBus.gntN === 9'h1FF; i++) tick(1);
		check("grants", $countones(~linkBus.gntN), 1);
		tick(3);
		check("grantSeen", $countones(grantSeen), 1);
		want = '0;
		tick(100);
		check("parked", {ownGrant, linkBus.busOe, linkBus.gntN}, 11'h7FF);
		$display("arbiter done");
	endtask : t_arbiter
	task t_abort;
		logic seen;
		for (int p = 0; p < 2; p++) begin
			seen = 0;
			selAck = p[0];
			tick(4);
			frm = 1;
			tick(1);
			frm = 0;
			for (int i = 0; i < 80; i++) begin
				tick(1);
				if (mAbort === 1'b1) seen = 1;
			end
			check("masterAbort", seen, !p[0]);
		end
		$display("abort done");
	endtask : t_abort
	task t_reset_power;
		srBit = 1;
		tick(4);
		check("bit reset", {linkBus.secResetN, linkBus.busOe}, 1);
		check("reset bus", linkBus.adOut, 0);
		srBit = 0;
		wait_sec_up();
		bpcs = 1;
		d3 = 1;
		tick(6);
		for (int i = 0; i < 8; i++) begin
			tick(1);
			check("stopped clocks", linkBus.secClockOutputs, 0);
		end
		d3 = 0;
		bpcs = 0;
		$display("reset and power done");
	endtask : t_reset_power
	task t_external;
		cfsN = 1;
		ownReq = 1;
		tick(6);
		check("request out", linkBus.gntN[0], 0);
		want = 9'h001;
		tick(10);
		check("ownGrant", ownGrant, 1);
		$display("external arbiter done");
	endtask : t_external
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		tick(20);
		rst_n = 1;
		t_mask_clocks();
		t_straps();
		t_errors();
		t_arbiter();
		t_abort();
		t_reset_power();
		t_external();
		tally_and_finish();
	end
endmodule : secondary_bus_side_control_tb
